// *** logic/banked_regfile.sv ***
// Banked word/byte/bit register file with data address generation and a
// classic Wishbone slave for the flags, segment and segment select registers.
// Assumes the execution unit drives its ports from logic on the same clock.
//
// Contract
// RL1 - Eight words visible at once, also reachable as sixteen bytes.
// RL2 - Lower four words come from one of four banks.
// RL3 - Adjacent word pairs form one 32-bit operand.
// RL4 - Upper four words are shared by all banks.
// RL5 - Word seven is the stack pointer; others may act as data pointers.
// RL6 - Every visible bit is readable and writable; hidden banks are not.
// RL7 - Optional eight extra words, word access only, never pointers.
// RL8 - Data addresses are 24 bits; fewer address lines may be fitted.
// RL9 - Addresses beyond on-chip RAM go to external memory.
// RL10 - Segment number supplies the upper eight address bits.
// RL11 - Two segment registers; each pointer stays linked until changed.
// RL12 - Direct mode reaches only the lowest 1K bytes of the segment.
// RL13 - Indirect address is segment above 16-bit pointer contents.
// RL14 - Offset mode adds signed 8 or 16-bit displacement, then prepends segment.
// RL15 - Auto-increment forms address as indirect, then increments the pointer.
// RL16 - Bank select bits in the processor flags word choose the bank.
// RL17 - Segment select register holds one bit per pointer.
// RL18 - Increment step is one for bytes, two for words.
// RL19 - Pointer arithmetic wraps in 16 bits, never touching segment bits.
//
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module banked_regfile
    import regfile_pkg::*;
#(
    parameter int EXT_EN = 1,
    parameter int RAM_BYTES = 2048,
    parameter int ADDR_LINES = 24
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [WB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rd_en_i,
    input wire logic rd_byte_i,
    input wire logic [3:0] rd_idx_i,
    output logic [WORD_W-1:0] rd_data_o,
    input wire logic wr_en_i,
    input wire logic wr_byte_i,
    input wire logic [3:0] wr_idx_i,
    input wire logic [WORD_W-1:0] wr_data_i,
    input wire logic [6:0] bit_addr_i,
    input wire logic bit_wr_en_i,
    input wire logic bit_val_i,
    output logic bit_o,
    input wire logic [1:0] dw_idx_i,
    input wire logic dw_wr_en_i,
    input wire logic [2*WORD_W-1:0] dw_wr_data_i,
    output logic [2*WORD_W-1:0] dw_rd_o,
    output logic [WORD_W-1:0] sp_o,
    input wire logic ag_req_i,
    input wire addr_mode_t ag_mode_i,
    input wire logic [2:0] ag_ptr_i,
    input wire logic ag_byte_i,
    input wire logic [WORD_W-1:0] ag_disp_i,
    input wire logic ag_disp_wide_i,
    input wire logic [DIR_W-1:0] ag_dir_i,
    input wire logic ag_done_i,
    output logic [ADDR_W-1:0] ag_addr_o,
    output logic ag_ext_o,
    output logic ag_valid_o
);

    localparam logic [ADDR_W-1:0] ADDR_MASK = ADDR_W'((64'h1 << ADDR_LINES) - 64'h1);
    localparam logic [ADDR_W-1:0] RAM_LAST = ADDR_W'(RAM_BYTES - 1);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [BYTE_W-1:0] get_byte(input logic [WORD_W-1:0] w,
                                                   input logic hi);
        get_byte = hi ? w[WORD_W-1:BYTE_W] : w[BYTE_W-1:0];
    endfunction

    function automatic logic [WORD_W-1:0] merge16(input logic [WORD_W-1:0] old,
                                                  input logic [31:0] dat,
                                                  input logic [1:0] sel);
        merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
    endfunction

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [NUM_BANKS*LOW_WORDS-1:0][WORD_W-1:0] bank_mem_reg;
    logic [VIS_WORDS-LOW_WORDS-1:0][WORD_W-1:0] upper_mem_reg;
    logic [EXT_WORDS-1:0][WORD_W-1:0] ext_mem_reg;
    logic [VIS_WORDS-1:0][WORD_W-1:0] vis_word;
    logic [VIS_WORDS-1:0][WORD_W-1:0] vis_next;
    logic [VIS_WORDS-1:0] vis_we;
    logic [WORD_W-1:0] flags_reg;
    logic [SEG_W-1:0] dseg_reg;
    logic [SEG_W-1:0] eseg_reg;
    logic [VIS_WORDS-1:0] ssel_reg;
    logic [BANK_W-1:0] bank_sel;
    logic inc_pend_reg;
    logic [2:0] inc_ptr_reg;
    logic [WORD_W-1:0] inc_step_reg;
    logic inc_fire;
    logic [SEG_W-1:0] ag_seg;
    logic [ADDR_W-1:0] ag_addr_raw;
    logic [ADDR_W-1:0] ag_addr_next;
    logic wb_req;

    assign bank_sel = flags_reg[BANK_LSB +: BANK_W]; // RL16
    assign inc_fire = ag_done_i && inc_pend_reg;
    assign sp_o = upper_mem_reg[SP_IDX - 3'(LOW_WORDS)]; // RL5

    // ------------------------------------------------------------------
    // Visible window
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < VIS_WORDS; gi++) begin : g_vis
            if (gi < LOW_WORDS) begin : g_low
                assign vis_word[gi] = bank_mem_reg[{bank_sel, 2'(gi)}]; // RL2
            end else begin : g_up
                assign vis_word[gi] = upper_mem_reg[gi-LOW_WORDS]; // RL4
            end
        end
    endgenerate

    // Later writers win: increment, double word, word or byte, then bit.
    always_comb begin
        vis_next = vis_word;
        vis_we = '0;
        if (inc_fire) begin
            vis_next[inc_ptr_reg] = vis_word[inc_ptr_reg] + inc_step_reg; // RL15 RL19
            vis_we[inc_ptr_reg] = 1'b1;
        end
        if (dw_wr_en_i) begin
            vis_next[{dw_idx_i, 1'b0}] = dw_wr_data_i[WORD_W-1:0]; // RL3
            vis_next[{dw_idx_i, 1'b1}] = dw_wr_data_i[2*WORD_W-1:WORD_W];
            vis_we[{dw_idx_i, 1'b0}] = 1'b1;
            vis_we[{dw_idx_i, 1'b1}] = 1'b1;
        end
        if (wr_en_i && wr_byte_i) begin
            if (wr_idx_i[0]) begin
                vis_next[wr_idx_i[3:1]][WORD_W-1:BYTE_W] = wr_data_i[BYTE_W-1:0]; // RL1
            end else begin
                vis_next[wr_idx_i[3:1]][BYTE_W-1:0] = wr_data_i[BYTE_W-1:0];
            end
            vis_we[wr_idx_i[3:1]] = 1'b1;
        end else if (wr_en_i && !wr_idx_i[3]) begin
            vis_next[wr_idx_i[2:0]] = wr_data_i; // RL1
            vis_we[wr_idx_i[2:0]] = 1'b1;
        end
        if (bit_wr_en_i) begin
            vis_next[bit_addr_i[6:4]][bit_addr_i[3:0]] = bit_val_i; // RL6
            vis_we[bit_addr_i[6:4]] = 1'b1;
        end
    end

    // Only the selected bank is written, so hidden banks keep their context.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            bank_mem_reg <= '0;
            upper_mem_reg <= '0;
        end else begin
            for (int i = 0; i < VIS_WORDS; i++) begin
                if (vis_we[i] && i < LOW_WORDS) begin
                    bank_mem_reg[{bank_sel, 2'(i)}] <= vis_next[i]; // RL2 RL6
                end else if (vis_we[i]) begin
                    upper_mem_reg[i-LOW_WORDS] <= vis_next[i]; // RL4
                end
            end
        end
    end

    // Extra words take whole-word writes only and never feed the pointer path.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            ext_mem_reg <= '0;
        end else if (EXT_EN != 0 && wr_en_i && !wr_byte_i && wr_idx_i[3]) begin
            ext_mem_reg[wr_idx_i[2:0]] <= wr_data_i; // RL7
        end
    end

    // ------------------------------------------------------------------
    // Read ports
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            rd_data_o <= '0;
            bit_o <= 1'b0;
            dw_rd_o <= '0;
        end else begin
            if (rd_en_i && rd_byte_i) begin
                rd_data_o <= {8'h00, get_byte(vis_word[rd_idx_i[3:1]], rd_idx_i[0])}; // RL1
            end else if (rd_en_i && rd_idx_i[3]) begin
                rd_data_o <= (EXT_EN != 0) ? ext_mem_reg[rd_idx_i[2:0]] : 16'h0000; // RL7
            end else if (rd_en_i) begin
                rd_data_o <= vis_word[rd_idx_i[2:0]]; // RL1
            end
            bit_o <= vis_word[bit_addr_i[6:4]][bit_addr_i[3:0]]; // RL6
            dw_rd_o <= {vis_word[{dw_idx_i, 1'b1}], vis_word[{dw_idx_i, 1'b0}]}; // RL3
        end
    end

    // ------------------------------------------------------------------
    // Address generation
    // ------------------------------------------------------------------
    assign ag_seg = ssel_reg[ag_ptr_i] ? eseg_reg : dseg_reg; // RL11 RL17

    data_addr_gen u_addr_gen (
        .mode_i(ag_mode_i),
        .ptr_i(vis_word[ag_ptr_i]),
        .seg_i(ag_seg),
        .dseg_i(dseg_reg),
        .disp_i(ag_disp_i),
        .disp_wide_i(ag_disp_wide_i),
        .dir_i(ag_dir_i),
        .addr_o(ag_addr_raw)
    );

    // Parts with fewer address lines simply lose the top bits.
    assign ag_addr_next = ag_addr_raw & ADDR_MASK; // RL8 RL10

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            ag_addr_o <= '0;
            ag_ext_o <= 1'b0;
            ag_valid_o <= 1'b0;
        end else begin
            ag_valid_o <= ag_req_i;
            if (ag_req_i) begin
                ag_addr_o <= ag_addr_next;
                ag_ext_o <= ag_addr_next > RAM_LAST; // RL9
            end
        end
    end

    // A new auto-increment request in the completing cycle re-arms the step.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            inc_pend_reg <= 1'b0;
            inc_ptr_reg <= '0;
            inc_step_reg <= STEP_WORD;
        end else if (ag_req_i && ag_mode_i == AM_AUTOINC) begin
            inc_pend_reg <= 1'b1;
            inc_ptr_reg <= ag_ptr_i;
            inc_step_reg <= ag_byte_i ? STEP_BYTE : STEP_WORD; // RL18
        end else if (ag_done_i) begin
            inc_pend_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------
    assign wb_req = wb_cyc_i && wb_stb_i;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_req && !wb_ack_o;
            if (wb_req && !wb_ack_o) begin
                case ({wb_adr_i[7:2], 2'b00})
                    REG_FLAGS: wb_dat_o <= {16'h0000, flags_reg};
                    REG_DSEG: wb_dat_o <= {24'h000000, dseg_reg};
                    REG_ESEG: wb_dat_o <= {24'h000000, eseg_reg};
                    REG_SSEL: wb_dat_o <= {24'h000000, ssel_reg};
                    REG_STATUS: wb_dat_o <= {7'h00, ag_ext_o, ag_addr_o};
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // Writes land on the acknowledging edge, when the master samples ack.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            flags_reg <= FLAGS_RST;
            dseg_reg <= SEG_RST;
            eseg_reg <= SEG_RST;
            ssel_reg <= SSEL_RST;
        end else if (wb_req && wb_we_i && wb_ack_o) begin
            case ({wb_adr_i[7:2], 2'b00})
                REG_FLAGS: flags_reg <= merge16(flags_reg, wb_dat_i, wb_sel_i[1:0]); // RL16
                REG_DSEG: dseg_reg <= wb_sel_i[0] ? wb_dat_i[7:0] : dseg_reg; // RL11
                REG_ESEG: eseg_reg <= wb_sel_i[0] ? wb_dat_i[7:0] : eseg_reg; // RL11
                REG_SSEL: ssel_reg <= wb_sel_i[0] ? wb_dat_i[7:0] : ssel_reg; // RL17
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    chk_word_view: assert property ( // RL1
        rd_en_i && !rd_byte_i && !rd_idx_i[3] |=> rd_data_o == $past(vis_word[rd_idx_i[2:0]]))
        else $error("word read does not match visible word");
    chk_byte_view: assert property ( // RL1
        rd_en_i && rd_byte_i |=> rd_data_o[15:8] == 8'h00
            && rd_data_o[7:0] == $past(get_byte(vis_word[rd_idx_i[3:1]], rd_idx_i[0])))
        else $error("byte read does not match word half");
    chk_bank_target: assert property ( // RL2
        vis_we[0] |=> bank_mem_reg[{$past(bank_sel), 2'b00}] == $past(vis_next[0]))
        else $error("low word write missed the selected bank");
    chk_upper_shared: assert property ( // RL4
        $changed(bank_sel) && $past(vis_we[7:4]) == 4'h0 |-> $stable(upper_mem_reg))
        else $error("upper words changed with the bank");
    chk_dw_pair: assert property ( // RL3
        ##1 dw_rd_o == {$past(vis_word[{dw_idx_i, 1'b1}]), $past(vis_word[{dw_idx_i, 1'b0}])})
        else $error("double word read is not the adjacent pair");
    chk_ext_bytes: assert property ( // RL7
        wr_en_i && wr_byte_i |=> $stable(ext_mem_reg))
        else $error("byte write reached an extra word");
    chk_bit_write: assert property ( // RL6
        bit_wr_en_i ##1 !$changed(bank_sel)
            |-> vis_word[$past(bit_addr_i[6:4])][$past(bit_addr_i[3:0])] == $past(bit_val_i))
        else $error("bit write lost");
    chk_indirect_addr: assert property ( // RL13
        ag_req_i && ag_mode_i == AM_INDIRECT |=> ag_valid_o
            && ag_addr_o == ($past({ag_seg, vis_word[ag_ptr_i]}) & ADDR_MASK))
        else $error("indirect address wrong");
    chk_offset_seg: assert property ( // RL19
        ag_req_i && ag_mode_i == AM_OFFSET |=> ag_addr_o[23:16] == ($past(ag_seg) & ADDR_MASK[23:16]))
        else $error("offset carried into segment");
    chk_direct_range: assert property ( // RL12
        ag_req_i && ag_mode_i == AM_DIRECT |=> ag_addr_o[15:10] == 6'h00)
        else $error("direct address beyond 1K");
    chk_ext_route: assert property ( // RL9
        ag_valid_o |-> ag_ext_o == (ag_addr_o > RAM_LAST))
        else $error("external routing wrong");
    chk_autoinc_step: assert property ( // RL15
        inc_fire && !wr_en_i && !dw_wr_en_i && !bit_wr_en_i ##1 !$changed(bank_sel)
            |-> vis_word[$past(inc_ptr_reg)]
                == 16'($past(vis_word[inc_ptr_reg]) + $past(inc_step_reg)))
        else $error("auto-increment step wrong");

endmodule

// *** logic/regfile_pkg.sv ***
// Constants, encodings and register map shared by the banked register file
// and its data address generator.
// Assumes a single core clock and a synchronous active-high reset.
package regfile_pkg;

    // ------------------------------------------------------------------
    // Register file geometry
    // ------------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int VIS_WORDS = 8;
    localparam int LOW_WORDS = 4;
    localparam int NUM_BANKS = 4;
    localparam int EXT_WORDS = 8;
    localparam int BANK_W = 2;
    localparam logic [2:0] SP_IDX = 3'h7;

    // ------------------------------------------------------------------
    // Data address space
    // ------------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam int SEG_W = 8;
    localparam int DIR_W = 10;
    localparam logic [WORD_W-1:0] STEP_BYTE = 16'h0001;
    localparam logic [WORD_W-1:0] STEP_WORD = 16'h0002;

    typedef enum logic [1:0] {
        AM_DIRECT = 2'b00,
        AM_INDIRECT = 2'b01,
        AM_OFFSET = 2'b10,
        AM_AUTOINC = 2'b11
    } addr_mode_t;

    // ------------------------------------------------------------------
    // Wishbone register map, byte addresses
    // ------------------------------------------------------------------
    localparam int WB_ADR_W = 8;
    localparam logic [7:0] REG_FLAGS = 8'h00;
    localparam logic [7:0] REG_DSEG = 8'h04;
    localparam logic [7:0] REG_ESEG = 8'h08;
    localparam logic [7:0] REG_SSEL = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam int BANK_LSB = 8;
    localparam logic [15:0] FLAGS_RST = 16'h0000;
    localparam logic [7:0] SEG_RST = 8'h00;
    localparam logic [7:0] SSEL_RST = 8'h00;

endpackage

// *** logic/data_addr_gen.sv ***
// Combinational 24-bit data address former for the four addressing modes.
// Assumes the caller supplies the pointer value and its linked segment.
`timescale 1ns/1ps
module data_addr_gen
    import regfile_pkg::*;
(
    input wire addr_mode_t mode_i,
    input wire logic [WORD_W-1:0] ptr_i,
    input wire logic [SEG_W-1:0] seg_i,
    input wire logic [SEG_W-1:0] dseg_i,
    input wire logic [WORD_W-1:0] disp_i,
    input wire logic disp_wide_i,
    input wire logic [DIR_W-1:0] dir_i,
    output logic [ADDR_W-1:0] addr_o
);

    logic [WORD_W-1:0] disp;
    logic [WORD_W-1:0] sum;

    // ------------------------------------------------------------------
    // Address forming
    // ------------------------------------------------------------------
    always_comb begin
        disp = disp_wide_i ? disp_i : {{BYTE_W{disp_i[BYTE_W-1]}}, disp_i[BYTE_W-1:0]}; // RL14
        // The sum is kept at 16 bits so a carry never leaks into the segment.
        sum = ptr_i + disp; // RL19
        case (mode_i)
            AM_DIRECT: addr_o = {dseg_i, {(WORD_W-DIR_W){1'b0}}, dir_i}; // RL12
            AM_INDIRECT: addr_o = {seg_i, ptr_i}; // RL13
            AM_OFFSET: addr_o = {seg_i, sum}; // RL14
            AM_AUTOINC: addr_o = {seg_i, ptr_i}; // RL15
            default: addr_o = {seg_i, ptr_i};
        endcase
    end

endmodule

// *** test/exec_unit_model.sv ***
// Stand-in for the execution unit: drives register, bit, pair and address ports.
// Assumes one core clock and that the bench calls one task at a time.
`timescale 1ns/1ps
module exec_unit_model
    import regfile_pkg::*;
(
    input wire logic sys_clk_i,
    output logic rd_en_o,
    output logic rd_byte_o,
    output logic [3:0] rd_idx_o,
    output logic wr_en_o,
    output logic wr_byte_o,
    output logic [3:0] wr_idx_o,
    output logic [WORD_W-1:0] wr_data_o,
    output logic [6:0] bit_addr_o,
    output logic bit_wr_en_o,
    output logic bit_val_o,
    output logic [1:0] dw_idx_o,
    output logic dw_wr_en_o,
    output logic [2*WORD_W-1:0] dw_wr_data_o,
    output logic ag_req_o,
    output addr_mode_t ag_mode_o,
    output logic [2:0] ag_ptr_o,
    output logic ag_byte_o,
    output logic [WORD_W-1:0] ag_disp_o,
    output logic ag_disp_wide_o,
    output logic [DIR_W-1:0] ag_dir_o,
    output logic ag_done_o
);
    initial begin
        {rd_en_o, rd_byte_o, rd_idx_o, wr_en_o, wr_byte_o, wr_idx_o, wr_data_o, bit_addr_o,
            bit_wr_en_o, bit_val_o, dw_idx_o, dw_wr_en_o, dw_wr_data_o, ag_req_o,
            ag_ptr_o, ag_byte_o, ag_disp_o, ag_disp_wide_o, ag_dir_o, ag_done_o} = '0;
        ag_mode_o = AM_DIRECT;
    end
    // Each strobe lives exactly one edge, so a slow caller cannot repeat a write.
    task automatic wr(input logic b, input logic [3:0] i, input logic [15:0] d);
        @(posedge sys_clk_i);
        {wr_en_o, wr_byte_o, wr_idx_o, wr_data_o} <= {1'b1, b, i, d};
        @(posedge sys_clk_i);
        wr_en_o <= 1'b0;
    endtask
    task automatic rd(input logic b, input logic [3:0] i);
        @(posedge sys_clk_i);
        {rd_en_o, rd_byte_o, rd_idx_o} <= {1'b1, b, i};
        @(posedge sys_clk_i);
        rd_en_o <= 1'b0;
    endtask
    task automatic bit_wr(input logic [6:0] a, input logic v);
        @(posedge sys_clk_i);
        {bit_addr_o, bit_wr_en_o, bit_val_o} <= {a, 1'b1, v};
        @(posedge sys_clk_i);
        bit_wr_en_o <= 1'b0;
    endtask
    task automatic dw_wr(input logic [1:0] k, input logic [31:0] d);
        @(posedge sys_clk_i);
        {dw_idx_o, dw_wr_en_o, dw_wr_data_o} <= {k, 1'b1, d};
        @(posedge sys_clk_i);
        dw_wr_en_o <= 1'b0;
    endtask
    task automatic ag(input addr_mode_t m, input logic [2:0] p, input logic b,
                      input logic [15:0] d, input logic w);
        @(posedge sys_clk_i);
        {ag_req_o, ag_ptr_o, ag_byte_o, ag_disp_o, ag_disp_wide_o, ag_dir_o} <=
            {1'b1, p, b, d, w, 10'h3FF};
        ag_mode_o <= m;
        @(posedge sys_clk_i);
        ag_req_o <= 1'b0;
    endtask
    task automatic done();
        @(posedge sys_clk_i);
        ag_done_o <= 1'b1;
        @(posedge sys_clk_i);
        ag_done_o <= 1'b0;
    endtask
endmodule

// *** test/tb_top.sv ***
// Self-checking bench: Wishbone master tasks plus the execution unit stand-in.
// Assumes the register file and its package from logic/, built with defaults.
`timescale 1ns/1ps
module tb_top;
    import regfile_pkg::*;
    localparam int RAM = 2048;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, bit_q, ag_ext, ag_valid;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0, rd_idx, wr_idx;
    logic [31:0] wdat = 32'h0, rdat, q, dw_rd, dw_wr_data;
    logic [15:0] rd_data, sp, wr_data, ag_disp;
    logic rd_en, rd_byte, wr_en, wr_byte, bit_wr_en, bit_val, dw_wr_en;
    logic ag_req, ag_byte, ag_wide, ag_done;
    logic [6:0] bit_addr;
    logic [1:0] dw_idx;
    logic [2:0] ag_ptr;
    logic [9:0] ag_dir;
    logic [23:0] ag_addr;
    addr_mode_t ag_mode;
    int fail_count = 0, checked = 0, cycles = 0;
    banked_regfile #(.EXT_EN(1), .RAM_BYTES(RAM), .ADDR_LINES(24)) u_dut (
        .sys_clk_i(clk), .sys_rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .rd_en_i(rd_en), .rd_byte_i(rd_byte), .rd_idx_i(rd_idx), .rd_data_o(rd_data),
        .wr_en_i(wr_en), .wr_byte_i(wr_byte), .wr_idx_i(wr_idx), .wr_data_i(wr_data),
        .bit_addr_i(bit_addr), .bit_wr_en_i(bit_wr_en), .bit_val_i(bit_val), .bit_o(bit_q),
        .dw_idx_i(dw_idx), .dw_wr_en_i(dw_wr_en), .dw_wr_data_i(dw_wr_data), .dw_rd_o(dw_rd),
        .sp_o(sp), .ag_req_i(ag_req), .ag_mode_i(ag_mode), .ag_ptr_i(ag_ptr), .ag_byte_i(ag_byte),
        .ag_disp_i(ag_disp), .ag_disp_wide_i(ag_wide), .ag_dir_i(ag_dir), .ag_done_i(ag_done),
        .ag_addr_o(ag_addr), .ag_ext_o(ag_ext), .ag_valid_o(ag_valid));
    exec_unit_model u_eu (
        .sys_clk_i(clk), .rd_en_o(rd_en), .rd_byte_o(rd_byte), .rd_idx_o(rd_idx),
        .wr_en_o(wr_en), .wr_byte_o(wr_byte), .wr_idx_o(wr_idx), .wr_data_o(wr_data),
        .bit_addr_o(bit_addr), .bit_wr_en_o(bit_wr_en), .bit_val_o(bit_val), .dw_idx_o(dw_idx),
        .dw_wr_en_o(dw_wr_en), .dw_wr_data_o(dw_wr_data), .ag_req_o(ag_req), .ag_mode_o(ag_mode),
        .ag_ptr_o(ag_ptr), .ag_byte_o(ag_byte), .ag_disp_o(ag_disp), .ag_disp_wide_o(ag_wide),
        .ag_dir_o(ag_dir), .ag_done_o(ag_done));
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic give_verdict();
        $display("checked %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // A hung handshake would otherwise stall the run forever.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count = fail_count + 1;
            give_verdict();
        end
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", n, e, s);
        end
    endtask
    // Ack is sampled at each edge before it updates; data is taken at the edge it is high.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hF};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic rdc(input string n, input logic b, input logic [3:0] i, input logic [15:0] e);
        u_eu.rd(b, i);
        #1 chk(n, {16'h0, rd_data}, {16'h0, e});
    endtask
    task automatic agc(input addr_mode_t m, input logic [2:0] p, input logic b,
                       input logic [15:0] d, input logic w, input logic [23:0] e);
        u_eu.ag(m, p, b, d, w);
        #1 chk("valid", {31'h0, ag_valid}, 32'h1);
        chk("addr", {7'h0, ag_ext, ag_addr}, {7'h0, e > RAM - 1, e});
    endtask
    task automatic test_reset();
        wb(1'b0, REG_FLAGS, 32'h0);
        chk("flags", q, {16'h0, FLAGS_RST});
        wb(1'b0, REG_SSEL, 32'h0);
        chk("ssel", q, {24'h0, SSEL_RST});
        $display("test reset done");
    endtask
    task automatic test_banks();
        u_eu.wr(1'b0, 4'h0, 16'hA0A0);
        u_eu.wr(1'b0, 4'h4, 16'hC4C4);
        wb(1'b1, REG_FLAGS, 32'h0000_0200);
        rdc("bank2 w0", 1'b0, 4'h0, 16'h0000);
        u_eu.wr(1'b0, 4'h0, 16'hB1B1);
        u_eu.bit_wr(7'h01, 1'b1);
        rdc("shared w4", 1'b0, 4'h4, 16'hC4C4);
        wb(1'b1, REG_FLAGS, 32'h0);
        rdc("bank0 w0", 1'b0, 4'h0, 16'hA0A0);
        wb(1'b1, REG_FLAGS, 32'h0000_0200);
        rdc("bank2 back", 1'b0, 4'h0, 16'hB1B3);
        wb(1'b1, REG_FLAGS, 32'h0);
        $display("test banks done");
    endtask
    task automatic test_access();
        u_eu.wr(1'b0, 4'h5, 16'h1234);
        u_eu.wr(1'b1, 4'hB, 16'hFF5A);
        rdc("w5", 1'b0, 4'h5, 16'h5A34);
        rdc("byte10", 1'b1, 4'hA, 16'h0034);
        u_eu.bit_wr(7'h6F, 1'b1);
        @(posedge clk);
        #1 chk("bit", {31'h0, bit_q}, 32'h1);
        rdc("w6", 1'b0, 4'h6, 16'h8000);
        u_eu.dw_wr(2'h1, 32'h1234ABCD);
        @(posedge clk);
        #1 chk("pair", dw_rd, 32'h1234ABCD);
        rdc("w3", 1'b0, 4'h3, 16'h1234);
        u_eu.wr(1'b0, 4'hA, 16'hBEEF);
        u_eu.wr(1'b1, 4'h4, 16'h0011);
        rdc("extra", 1'b0, 4'hA, 16'hBEEF);
        rdc("w2", 1'b0, 4'h2, 16'hAB11);
        u_eu.wr(1'b0, 4'h7, 16'h7FFE);
        @(posedge clk);
        #1 chk("sp", {16'h0, sp}, 32'h7FFE);
        $display("test access done");
    endtask
    task automatic test_addr();
        wb(1'b1, REG_DSEG, 32'h12);
        wb(1'b1, REG_ESEG, 32'h34);
        wb(1'b1, REG_SSEL, 32'h02);
        u_eu.wr(1'b0, 4'h1, 16'hFFFF);
        u_eu.wr(1'b0, 4'h2, 16'h0700);
        agc(AM_DIRECT, 3'h1, 1'b0, 16'h0, 1'b0, 24'h1203FF);
        agc(AM_INDIRECT, 3'h1, 1'b0, 16'h0, 1'b0, 24'h34FFFF);
        agc(AM_OFFSET, 3'h1, 1'b0, 16'hAB02, 1'b0, 24'h340001);
        agc(AM_OFFSET, 3'h2, 1'b0, 16'hFF80, 1'b0, 24'h120680);
        agc(AM_OFFSET, 3'h2, 1'b0, 16'h0100, 1'b1, 24'h120800);
        agc(AM_AUTOINC, 3'h1, 1'b1, 16'h0, 1'b0, 24'h34FFFF);
        u_eu.done();
        rdc("r1 wrap", 1'b0, 4'h1, 16'h0000);
        agc(AM_AUTOINC, 3'h2, 1'b0, 16'h0, 1'b0, 24'h120700);
        u_eu.done();
        rdc("r2 step", 1'b0, 4'h2, 16'h0702);
        wb(1'b1, REG_DSEG, 32'h0);
        u_eu.wr(1'b0, 4'h2, 16'h07FF);
        agc(AM_INDIRECT, 3'h2, 1'b0, 16'h0, 1'b0, 24'h0007FF);
        agc(AM_OFFSET, 3'h2, 1'b0, 16'h0001, 1'b1, 24'h000800);
        wb(1'b0, REG_STATUS, 32'h0);
        chk("status", q, 32'h0100_0800);
        wb(1'b1, 8'h20, 32'hFFFF);
        wb(1'b0, 8'h20, 32'h0);
        chk("unmapped", q, 32'h0);
        $display("test addr done");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_banks();
        test_access();
        test_addr();
        give_verdict();
    end
endmodule
